// ---- common/dsg_pkg.sv ----
// package: register map, field layout and carrier types of the deep-sleep clock gate bank one
// Behaviour
// - each writable bit clocks exactly one unit
// - access to an unclocked unit gets bus fault
// - all gating bits reset to zero
// - run, sleep and deep-sleep gate registers kept
// - sleep registers apply only with auto gating set
// - bits 17 and 16 gate counters one, zero
// - bit 12 gates two-wire unit zero
// - bit 4 gates sync serial unit zero
// - bit 0 gates async serial unit zero
package dsg_pkg;

	localparam int unsigned DATA_W    = 32;
	localparam int unsigned ADDR_W    = 12;
	localparam int unsigned STRB_W    = DATA_W / 8;
	localparam int unsigned NUM_UNITS = 32;
	localparam int unsigned UNIT_W    = 5;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFS_RUN_GATE   = 12'h104;
	localparam logic [ADDR_W-1:0] OFS_SLEEP_GATE = 12'h114;
	localparam logic [ADDR_W-1:0] OFS_DEEP_GATE  = 12'h124;
	localparam logic [ADDR_W-1:0] OFS_RUN_CFG    = 12'h140;
	localparam logic [ADDR_W-1:0] OFS_FAULT_STAT = 12'h150;
	localparam logic [ADDR_W-1:0] OFS_FAULT_MASK = 12'h154;

	// gate field positions
	localparam int unsigned BIT_COMPARATOR_ONE   = 25;
	localparam int unsigned BIT_COMPARATOR_ZERO  = 24;
	localparam int unsigned BIT_GP_COUNTER_THREE = 19;
	localparam int unsigned BIT_GP_COUNTER_TWO   = 18;
	localparam int unsigned BIT_GP_COUNTER_ONE   = 17;
	localparam int unsigned BIT_GP_COUNTER_ZERO  = 16;
	localparam int unsigned BIT_TWO_WIRE_ZERO    = 12;
	localparam int unsigned BIT_SYNC_SERIAL_ZERO = 4;
	localparam int unsigned BIT_ASYNC_SERIAL_ZERO = 0;

	localparam logic [DATA_W-1:0] GATE_WR_MASK =
		(32'h1 << BIT_COMPARATOR_ONE)   | (32'h1 << BIT_COMPARATOR_ZERO) |
		(32'h1 << BIT_GP_COUNTER_THREE) | (32'h1 << BIT_GP_COUNTER_TWO) |
		(32'h1 << BIT_GP_COUNTER_ONE)   | (32'h1 << BIT_GP_COUNTER_ZERO) |
		(32'h1 << BIT_TWO_WIRE_ZERO)    | (32'h1 << BIT_SYNC_SERIAL_ZERO) |
		(32'h1 << BIT_ASYNC_SERIAL_ZERO);
	localparam logic [DATA_W-1:0] GATE_RESET = 32'h0000_0000;

	// run clock configuration fields
	localparam int unsigned       BIT_AUTO_CLOCK_GATING = 0;
	localparam logic [DATA_W-1:0] CFG_WR_MASK = 32'h1 << BIT_AUTO_CLOCK_GATING;
	localparam logic              CFG_RESET   = 1'b0;

	localparam logic [DATA_W-1:0] FAULT_RESET = 32'h0000_0000;
	localparam logic [DATA_W-1:0] RDATA_NONE  = 32'h0000_0000;

	typedef enum logic [1:0] {
		DSG_MODE_RUN,
		DSG_MODE_SLEEP,
		DSG_MODE_DEEP
	} dsg_mode_t;

	typedef struct packed {
		logic              valid;
		logic              write;
		logic [UNIT_W-1:0] unit;
	} dsg_periph_req_t;

	typedef struct packed {
		logic fault;
		logic ok;
	} dsg_periph_rsp_t;

endpackage

// ---- src/dsg_fault_check.sv ----
// module: decides whether a peripheral access hits a clocked or an unclocked unit
`timescale 1ns/10ps
module dsg_fault_check #(
	parameter int unsigned NUM_UNITS = 32,
	parameter int unsigned UNIT_W    = 5
) (
	// unit clock enables as seen by the units
	input  wire logic [NUM_UNITS-1:0] unit_en,
	// access attempt
	input  wire logic                 req_valid,
	input  wire logic [UNIT_W-1:0]    req_unit,
	// verdict
	output logic                      fault,
	output logic                      ok,
	output logic [NUM_UNITS-1:0]      fault_onehot
);

	logic [NUM_UNITS-1:0] sel;

	assign sel          = req_valid ? (NUM_UNITS'(1) << req_unit) : '0;
	// an unclocked unit cannot answer, so the access faults
	assign fault        = |(sel & ~unit_en);
	assign ok           = |(sel & unit_en);
	assign fault_onehot = sel & ~unit_en;

endmodule // dsg_fault_check

// ---- src/dsg_clock_gate_bank.sv ----
// module: deep-sleep clock gate bank one with run/sleep siblings, apb slave and fault interrupt
`timescale 1ns/10ps
module dsg_clock_gate_bank (
	// clock and reset
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	// apb slave
	input  wire logic                     psel,
	input  wire logic                     penable,
	input  wire logic                     pwrite,
	input  wire logic [dsg_pkg::ADDR_W-1:0] paddr,
	input  wire logic [dsg_pkg::DATA_W-1:0] pwdata,
	input  wire logic [dsg_pkg::STRB_W-1:0] pstrb,
	output logic      [dsg_pkg::DATA_W-1:0] prdata,
	output logic                          pready,
	output logic                          pslverr,
	// power management mode
	input  wire dsg_pkg::dsg_mode_t       power_mode,
	// unit clock enables
	output logic      [dsg_pkg::NUM_UNITS-1:0] unit_clk_en,
	// peripheral access check
	input  wire dsg_pkg::dsg_periph_req_t periph_req,
	output dsg_pkg::dsg_periph_rsp_t      periph_rsp,
	// interrupt
	output logic                          irq
);
	import dsg_pkg::*;

	logic [DATA_W-1:0]    run_gate_ff;
	logic [DATA_W-1:0]    sleep_gate_ff;
	logic [DATA_W-1:0]    deep_gate_ff;
	logic                 acg_ff;
	logic [DATA_W-1:0]    fault_stat_ff;
	logic [DATA_W-1:0]    nxt_fault_stat;
	logic [DATA_W-1:0]    fault_mask_ff;
	logic [DATA_W-1:0]    prdata_ff;
	logic [DATA_W-1:0]    nxt_prdata;
	logic                 pready_ff;
	logic                 pslverr_ff;
	logic                 nxt_pslverr;
	logic [NUM_UNITS-1:0] clk_en_ff;
	logic [NUM_UNITS-1:0] nxt_clk_en;
	dsg_periph_rsp_t      periph_rsp_ff;
	logic                 irq_ff;
	logic                 setup_phase;
	logic                 access_done;
	logic                 wr_take;
	logic                 rd_take;
	logic                 sel_run_gate;
	logic                 sel_sleep_gate;
	logic                 sel_deep_gate;
	logic                 sel_run_cfg;
	logic                 sel_fault_stat;
	logic                 sel_fault_mask;
	logic                 wr_run_gate;
	logic                 wr_sleep_gate;
	logic                 wr_deep_gate;
	logic                 wr_run_cfg;
	logic                 wr_fault_mask;
	logic                 rd_fault_stat;
	logic [DATA_W-1:0]    byte_mask;
	logic [DATA_W-1:0]    rd_clear;
	logic                 chk_fault;
	logic                 chk_ok;
	logic [NUM_UNITS-1:0] chk_fault_onehot;

	// merge a strobed write into a register, touching writable bits only
	function automatic logic [DATA_W-1:0] merge_write(
		input logic [DATA_W-1:0] old_val,
		input logic [DATA_W-1:0] wdata,
		input logic [DATA_W-1:0] bmask,
		input logic [DATA_W-1:0] wmask
	);
		logic [DATA_W-1:0] m;
		m = bmask & wmask;
		return (old_val & ~m) | (wdata & m);
	endfunction

	// apb phases: data is captured in setup, answer given in the single access cycle
	assign setup_phase = psel & ~penable;
	assign access_done = psel & penable & pready_ff;
	assign wr_take     = access_done & pwrite & ~pslverr_ff;
	assign rd_take     = access_done & ~pwrite & ~pslverr_ff;

	always_comb begin
		byte_mask = '0;
		for (int i = 0; i < STRB_W; i++) begin
			byte_mask[i*8 +: 8] = {8{pstrb[i]}};
		end
	end

	// read decode and unmapped-address answer
	always_comb begin
		nxt_prdata  = RDATA_NONE;
		nxt_pslverr = 1'b0;
		case (paddr)
			OFS_RUN_GATE: begin
				nxt_prdata = run_gate_ff;
			end
			OFS_SLEEP_GATE: begin
				nxt_prdata = sleep_gate_ff;
			end
			OFS_DEEP_GATE: begin
				nxt_prdata = deep_gate_ff;
			end
			OFS_RUN_CFG: begin
				nxt_prdata = (DATA_W'(acg_ff) << BIT_AUTO_CLOCK_GATING) & CFG_WR_MASK;
			end
			OFS_FAULT_STAT: begin
				nxt_prdata = fault_stat_ff;
			end
			OFS_FAULT_MASK: begin
				nxt_prdata = fault_mask_ff;
			end
			default: begin
				nxt_pslverr = 1'b1;
			end
		endcase
	end

	// one select per register, shared by the write strobes and the read clear
	always_comb begin
		sel_run_gate   = 1'b0;
		sel_sleep_gate = 1'b0;
		sel_deep_gate  = 1'b0;
		sel_run_cfg    = 1'b0;
		sel_fault_stat = 1'b0;
		sel_fault_mask = 1'b0;
		case (paddr)
			OFS_RUN_GATE: begin
				sel_run_gate = 1'b1;
			end
			OFS_SLEEP_GATE: begin
				sel_sleep_gate = 1'b1;
			end
			OFS_DEEP_GATE: begin
				sel_deep_gate = 1'b1;
			end
			OFS_RUN_CFG: begin
				sel_run_cfg = 1'b1;
			end
			OFS_FAULT_STAT: begin
				sel_fault_stat = 1'b1;
			end
			OFS_FAULT_MASK: begin
				sel_fault_mask = 1'b1;
			end
			default: begin
				sel_run_gate = 1'b0;
			end
		endcase
	end

	// the fault status has no write strobe: writes to it are ignored
	assign wr_run_gate   = wr_take & sel_run_gate;
	assign wr_sleep_gate = wr_take & sel_sleep_gate;
	assign wr_deep_gate  = wr_take & sel_deep_gate;
	assign wr_run_cfg    = wr_take & sel_run_cfg;
	assign wr_fault_mask = wr_take & sel_fault_mask;
	assign rd_fault_stat = rd_take & sel_fault_stat;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_ff <= 1'b0;
		end else begin
			pready_ff <= setup_phase;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff  <= RDATA_NONE;
			pslverr_ff <= 1'b0;
		end else if (setup_phase) begin
			prdata_ff  <= pwrite ? RDATA_NONE : nxt_prdata;
			pslverr_ff <= nxt_pslverr;
		end else if (access_done) begin
			prdata_ff  <= RDATA_NONE;
			pslverr_ff <= 1'b0;
		end
	end

	// three parallel gate registers, reserved bits held at zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			run_gate_ff <= GATE_RESET;
		end else if (wr_run_gate) begin
			run_gate_ff <= merge_write(run_gate_ff, pwdata, byte_mask, GATE_WR_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sleep_gate_ff <= GATE_RESET;
		end else if (wr_sleep_gate) begin
			sleep_gate_ff <= merge_write(sleep_gate_ff, pwdata, byte_mask, GATE_WR_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			deep_gate_ff <= GATE_RESET;
		end else if (wr_deep_gate) begin
			// only the unit bits take a write; reserved bits stay zero whatever is written back
			deep_gate_ff <= merge_write(deep_gate_ff, pwdata, byte_mask, GATE_WR_MASK);
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			acg_ff <= CFG_RESET;
		end else if (wr_run_cfg && pstrb[BIT_AUTO_CLOCK_GATING / 8]) begin
			acg_ff <= pwdata[BIT_AUTO_CLOCK_GATING];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_mask_ff <= FAULT_RESET;
		end else if (wr_fault_mask) begin
			fault_mask_ff <= merge_write(fault_mask_ff, pwdata, byte_mask, GATE_WR_MASK);
		end
	end

	// mode picks the register; sleep registers are ignored unless auto gating is on
	always_comb begin
		nxt_clk_en = run_gate_ff;
		case (power_mode)
			DSG_MODE_RUN: begin
				nxt_clk_en = run_gate_ff;
			end
			DSG_MODE_SLEEP: begin
				if (acg_ff) begin
					nxt_clk_en = sleep_gate_ff;
				end
			end
			DSG_MODE_DEEP: begin
				if (acg_ff) begin
					nxt_clk_en = deep_gate_ff;
				end
			end
			default: begin
				nxt_clk_en = run_gate_ff;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			clk_en_ff <= GATE_RESET;
		end else begin
			clk_en_ff <= nxt_clk_en & GATE_WR_MASK;
		end
	end

	// access check against the enables the units actually see
	dsg_fault_check #(
		.NUM_UNITS (NUM_UNITS),
		.UNIT_W    (UNIT_W)
	) u_fault_check (
		.unit_en      (clk_en_ff),
		.req_valid    (periph_req.valid),
		.req_unit     (periph_req.unit),
		.fault        (chk_fault),
		.ok           (chk_ok),
		.fault_onehot (chk_fault_onehot)
	);

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			periph_rsp_ff <= '0;
		end else begin
			periph_rsp_ff.fault <= chk_fault;
			periph_rsp_ff.ok    <= chk_ok;
		end
	end

	// read clears only the bits that were returned, so a new fault is never lost
	assign rd_clear = rd_fault_stat ? prdata_ff : '0;

	always_comb begin
		nxt_fault_stat = (fault_stat_ff & ~rd_clear) | chk_fault_onehot;
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fault_stat_ff <= FAULT_RESET;
		end else begin
			fault_stat_ff <= nxt_fault_stat;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= |(nxt_fault_stat & fault_mask_ff);
		end
	end

	assign prdata      = prdata_ff;
	assign pready      = pready_ff;
	assign pslverr     = pslverr_ff;
	assign unit_clk_en = clk_en_ff;
	assign periph_rsp  = periph_rsp_ff;
	assign irq         = irq_ff;

endmodule // dsg_clock_gate_bank

// ---- tb/dsg_clock_gate_bank_properties.sv ----
// checker: port-level properties of the deep-sleep clock gate bank
`timescale 1ns/10ps
module dsg_clock_gate_bank_chk (
	// clock and reset
	input wire logic                             pclk,
	input wire logic                             presetn,
	// apb slave
	input wire logic                             psel,
	input wire logic                             penable,
	input wire logic                             pready,
	input wire logic                             pslverr,
	// mode, enables and access check
	input wire dsg_pkg::dsg_mode_t               power_mode,
	input wire logic [dsg_pkg::NUM_UNITS-1:0]    unit_clk_en,
	input wire dsg_pkg::dsg_periph_req_t         periph_req,
	input wire dsg_pkg::dsg_periph_rsp_t         periph_rsp
);
	import dsg_pkg::*;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_setup;
		psel && !penable;
	endsequence
	// no bus traffic and a steady mode
	sequence s_quiet;
		!psel && $stable(power_mode);
	endsequence
	sequence s_gated_hit;
		periph_req.valid && !unit_clk_en[periph_req.unit];
	endsequence
	sequence s_clocked_hit;
		periph_req.valid && unit_clk_en[periph_req.unit];
	endsequence

	chk_ready_after_setup: assert property (s_setup |=> pready)
		else $error("no ready after setup");
	chk_err_with_ready: assert property (pslverr |-> pready)
		else $error("slave error without ready");
	chk_reserved_gates_low: assert property ((unit_clk_en & 32'hfcf0_efee) == '0)
		else $error("reserved enable bit high");
	chk_gated_access_faults: assert property (s_gated_hit |=> periph_rsp.fault && !periph_rsp.ok)
		else $error("gated unit access not faulted");
	chk_clocked_access_ok: assert property (s_clocked_hit |=> periph_rsp.ok && !periph_rsp.fault)
		else $error("clocked unit access not accepted");
	chk_idle_no_answer: assert property (!periph_req.valid |=> periph_rsp == '0)
		else $error("answer without access");
	chk_reset_all_gated: assert property ($rose(presetn) |-> unit_clk_en == '0)
		else $error("enable high after reset");
	chk_enables_hold: assert property (s_quiet [*3] |=> $stable(unit_clk_en))
		else $error("enables moved without cause");
endmodule // dsg_clock_gate_bank_chk

bind dsg_clock_gate_bank dsg_clock_gate_bank_chk i_chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr,
	.power_mode, .unit_clk_en, .periph_req, .periph_rsp);

// ---- tb/test_deep_sleep_clock_gate_bank_one.sv ----
// testbench: self-checking bench of the deep-sleep clock gate bank
`timescale 1ns/10ps
module test_deep_sleep_clock_gate_bank_one;
	import dsg_pkg::*;
	logic                 pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
	logic [ADDR_W-1:0]    paddr;
	logic [DATA_W-1:0]    pwdata, prdata, rd;
	logic [STRB_W-1:0]    pstrb;
	logic [NUM_UNITS-1:0] unit_clk_en;
	dsg_mode_t            power_mode;
	dsg_periph_req_t      periph_req;
	dsg_periph_rsp_t      periph_rsp;
	int                   miscompares, total_checks;
	int                   bits[9] = '{25, 24, 19, 18, 17, 16, 12, 4, 0};
	logic [31:0]          exp_m[2][3] = '{'{32'h1, 32'h1, 32'h1}, '{32'h1, 32'h10, 32'h1000}};

	dsg_clock_gate_bank i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata,
		.pready, .pslverr, .power_mode, .unit_clk_en, .periph_req, .periph_rsp, .irq);

	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish();
		if (miscompares == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// one apb transfer, held until pready is sampled high
	task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0; penable <= 1'b0;
	endtask

	task automatic settle();
		repeat (3) @(posedge pclk);
		#1;
	endtask

	// one access attempt on a unit, verdict one cycle later
	task automatic periph(input logic [4:0] u, input logic f);
		@(posedge pclk);
		periph_req <= '{1'b1, 1'b0, u};
		@(posedge pclk);
		periph_req.valid <= 1'b0;
		#1 chk(32'(periph_rsp), {30'h0, f, !f});
	endtask

	task automatic reset_values();
		settle();
		chk(unit_clk_en, 32'h0);
		foreach (exp_m[0][m]) begin
			apb(1'b0, 12'h104 + 12'h10 * 12'(m), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b1, OFS_DEEP_GATE, 32'hffff_ffff);
		apb(1'b0, OFS_DEEP_GATE, 32'h0);
		chk(rd, 32'h030f_1011);
		apb(1'b0, 12'h200, 32'h0);
		chk({31'h0, err}, 32'h1);
		chk(rd, 32'h0);
		pstrb <= 4'h2;
		apb(1'b1, OFS_DEEP_GATE, 32'h0);
		pstrb <= 4'hf;
		apb(1'b0, OFS_DEEP_GATE, 32'h0);
		chk(rd, 32'h030f_0011);
	endtask

	task automatic mode_select();
		apb(1'b1, OFS_RUN_GATE, 32'h1);
		apb(1'b1, OFS_SLEEP_GATE, 32'h10);
		apb(1'b1, OFS_DEEP_GATE, 32'h1000);
		for (int a = 0; a < 2; a++) begin
			apb(1'b1, OFS_RUN_CFG, 32'(a));
			for (int m = 2; m >= 0; m--) begin
				@(posedge pclk) power_mode <= dsg_mode_t'(m);
				settle();
				chk(unit_clk_en, exp_m[a][m]);
			end
		end
		@(posedge pclk) power_mode <= dsg_mode_t'(2'h3);
		settle();
		chk(unit_clk_en, 32'h1);
	endtask

	task automatic each_gate();
		@(posedge pclk) power_mode <= DSG_MODE_DEEP;
		foreach (bits[i]) begin
			apb(1'b1, OFS_DEEP_GATE, 32'h1 << bits[i]);
			settle();
			chk(unit_clk_en, 32'h1 << bits[i]);
			periph(5'(bits[i]), 1'b0);
			periph(5'(bits[i] ^ 1), 1'b1);
		end
	endtask

	task automatic fault_irq();
		apb(1'b0, OFS_FAULT_STAT, 32'h0);
		chk(rd, 32'h030f_2022);
		apb(1'b1, OFS_FAULT_MASK, 32'h10);
		apb(1'b1, OFS_DEEP_GATE, 32'h0);
		settle();
		periph(5'd4, 1'b1);
		chk({31'h0, irq}, 32'h1);
		apb(1'b0, OFS_FAULT_STAT, 32'h0);
		chk(rd, 32'h10);
		#1 chk({31'h0, irq}, 32'h0);
		periph(5'd12, 1'b1);
		chk({31'h0, irq}, 32'h0);
	endtask

	// reset in mid-run: enables, run gate and auto gating all return to zero
	task automatic reset_mid();
		@(posedge pclk) power_mode <= DSG_MODE_RUN;
		apb(1'b1, OFS_RUN_GATE, 32'h0300_0000);
		settle();
		chk(unit_clk_en, 32'h0300_0000);
		@(posedge pclk) presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		#1 chk(unit_clk_en, 32'h0);
		apb(1'b0, OFS_RUN_GATE, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, OFS_RUN_CFG, 32'h0);
		chk(rd, 32'h0);
	endtask

	initial begin
		presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
		pstrb = 4'hf; power_mode = DSG_MODE_RUN; periph_req = '0;
		miscompares = 0; total_checks = 0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		reset_values();
		mode_select();
		each_gate();
		fault_irq();
		reset_mid();
		tally_and_finish();
	end

	initial begin
		repeat (20000) @(posedge pclk);
		miscompares++;
		tally_and_finish();
	end
endmodule // test_deep_sleep_clock_gate_bank_one
